/* File: inc/asrx_map.svh */
`ifndef ASRX_MAP_SVH
`define ASRX_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ASRX_OFF_INTCTL   8'h00
`define ASRX_OFF_IRQFLG   8'h04
`define ASRX_OFF_IRQEN    8'h08
`define ASRX_OFF_IRQPRI   8'h0c
`define ASRX_OFF_RCSTAT   8'h10
`define ASRX_OFF_RXBUF    8'h14
`define ASRX_OFF_TXSTAT   8'h18
`define ASRX_OFF_BAUD     8'h1c
`define ASRX_OFF_DIVHI    8'h20
`define ASRX_OFF_DIVLO    8'h24

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ASRX_GIE_BIT      7
`define ASRX_PERIPHERAL_IRQ_ENABLE_BIT     6
`define ASRX_RC_BIT       5
`define ASRX_SERIAL_PORT_ENABLE_BIT     7
`define ASRX_RX9_BIT      6
`define ASRX_CONTINUOUS_RECEIVE_ENABLE_BIT     4
`define ASRX_ADDRESS_DETECT_ENABLE_BIT    3
`define ASRX_FRAMING_ERROR_FLAG_BIT     2
`define ASRX_OVERRUN_ERROR_FLAG_BIT     1
`define ASRX_NINTH_RECEIVED_BIT_BIT     0
`define ASRX_SYNC_BIT     4
`define ASRX_HIGH_RATE_SELECT_BIT     2
`define ASRX_RCIDL_BIT    6
`define ASRX_WIDE_DIVISOR_SELECT_BIT    3
`define ASRX_WUE_BIT      1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ASRX_RST_BIT      1'b0
`define ASRX_RST_BYTE     8'h00
`define ASRX_RST_LINE     1'b1

// ----------------------------------------------------------------
// Oversampling and data bit counts
// ----------------------------------------------------------------
`define ASRX_LAST_STD     4'hf
`define ASRX_LAST_FAST    4'h3
`define ASRX_VOTE_STD     4'h6
`define ASRX_VOTE_FAST    4'h0
`define ASRX_STOP_STD     4'h9
`define ASRX_STOP_FAST    4'h3
`define ASRX_PRE_X64      2'h3
`define ASRX_BITS_NINE    4'h8
`define ASRX_BITS_EIGHT   4'h7

`endif

/* File: inc/asrx_pkg.sv */
`default_nettype none
package asrx_pkg;
  typedef enum logic [5:0] {
    ASRX_IDLE      = 6'b000001,
    ASRX_START     = 6'b000010,
    ASRX_DATA      = 6'b000100,
    ASRX_STOP      = 6'b001000,
    ASRX_WAKE_FALL = 6'b010000,
    ASRX_WAKE_RISE = 6'b100000
  } asrx_state_t;
endpackage
`default_nettype wire

/* File: verilog/asrx_receiver.sv */
// Operation
// - Bits are oversampled sixteen times per bit, four with wide divisor and high rate both set; the shifter advances once per bit.
// - Nine data bits per frame when nine-bit receive is set, else eight.
// - Frames are accepted only while continuous receive enable is set.
// - A completed frame sets the receive flag and may raise the interrupt.
// - Ninth bit, framing and overrun errors are readable in the receive status register.
// - Reading the receive buffer returns the low eight received data bits.
// - Clearing continuous receive enable clears the latched error condition.
// - Nine-bit plus address detect enables address mode; clearing it admits all frames.
// - The receive interrupt goes out at the level chosen by the priority bit.
// - In sleep the baud generator stops and no frame is received.
// - Wake-up on line activity works only in asynchronous operation.
// - With wake-up enabled normal reception stops and the line is watched.
// - A falling line edge is the wake-up event while wake-up is enabled.
// - The wake-up event sets the receive flag; a pin request serves sleep.
// - Reading the receive buffer clears the pending receive flag.
// - First rising edge after the wake event clears wake-up enable by hardware.
// - Frames are NRZ: one start bit, eight or nine data bits, one stop bit.
// - Data bits travel least significant bit first.
`include "asrx_map.svh"
`default_nettype none
module asrx_receiver
  import asrx_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Serial line and power state
  input  wire logic        receive_line,
  input  wire logic        sleep,
  // Interrupt and wake outputs
  output logic             irq_high,
  output logic             irq_low,
  output logic             wake_request
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic        global_irq_enable, peripheral_irq_enable;
  logic        receive_irq_enable, receive_irq_priority;
  logic        serial_port_enable, nine_bit_receive_enable;
  logic        continuous_receive_enable, address_detect_enable;
  logic        sync_mode, high_rate_select, wide_divisor_select;
  logic        wakeup_enable;
  logic        receive_complete_flag, framing_error_flag;
  logic        overrun_error_flag, ninth_received_bit;
  logic [7:0]  rx_data, div_hi, div_lo;
  logic        rx_s1, rx_s2, rx_s3, rx_level, rx_prev;
  logic [15:0] brg_cnt;
  logic [1:0]  pre_cnt;
  logic [3:0]  tick_cnt, bit_idx;
  logic [2:0]  vote;
  logic [8:0]  shreg;
  logic        wr_pend, addr_ok_q;
  logic [7:0]  addr_q;
  asrx_state_t state, next_state;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire       acc      = hsel & hready & htrans[1];
  wire       addr_ok  = haddr[31:8] == 24'h000000;
  wire [7:0] a        = haddr[7:0];
  wire       rd_acc   = acc & ~hwrite & addr_ok;
  wire       rd_rxbuf = rd_acc & (a == `ASRX_OFF_RXBUF);
  wire       wr_ok    = wr_pend & addr_ok_q;
  wire       wr_int   = wr_ok & (addr_q == `ASRX_OFF_INTCTL);
  wire       wr_en    = wr_ok & (addr_q == `ASRX_OFF_IRQEN);
  wire       wr_pri   = wr_ok & (addr_q == `ASRX_OFF_IRQPRI);
  wire       wr_rcs   = wr_ok & (addr_q == `ASRX_OFF_RCSTAT);
  wire       wr_txs   = wr_ok & (addr_q == `ASRX_OFF_TXSTAT);
  wire       wr_baud  = wr_ok & (addr_q == `ASRX_OFF_BAUD);
  wire       wr_dhi   = wr_ok & (addr_q == `ASRX_OFF_DIVHI);
  wire       wr_dlo   = wr_ok & (addr_q == `ASRX_OFF_DIVLO);
  wire [7:0] wd       = hwdata[7:0];
  wire       rx_idle  = state == ASRX_IDLE;

  wire [7:0] r_int = {global_irq_enable, peripheral_irq_enable, 6'h00};
  wire [7:0] r_flg = {2'h0, receive_complete_flag, 5'h00};
  wire [7:0] r_en  = {2'h0, receive_irq_enable, 5'h00};
  wire [7:0] r_pri = {2'h0, receive_irq_priority, 5'h00};
  wire [7:0] r_rcs = {serial_port_enable, nine_bit_receive_enable, 1'b0,
                      continuous_receive_enable, address_detect_enable,
                      framing_error_flag, overrun_error_flag, ninth_received_bit};
  wire [7:0] r_txs = {3'h0, sync_mode, 1'b0, high_rate_select, 2'h0};
  wire [7:0] r_bd  = {1'b0, rx_idle, 2'h0, wide_divisor_select, 1'b0, wakeup_enable, 1'b0};
  wire [7:0] rd_byte =
      (a == `ASRX_OFF_INTCTL) ? r_int :
      (a == `ASRX_OFF_IRQFLG) ? r_flg :
      (a == `ASRX_OFF_IRQEN)  ? r_en  :
      (a == `ASRX_OFF_IRQPRI) ? r_pri :
      (a == `ASRX_OFF_RCSTAT) ? r_rcs :
      (a == `ASRX_OFF_RXBUF)  ? rx_data :
      (a == `ASRX_OFF_TXSTAT) ? r_txs :
      (a == `ASRX_OFF_BAUD)   ? r_bd  :
      (a == `ASRX_OFF_DIVHI)  ? div_hi :
      (a == `ASRX_OFF_DIVLO)  ? div_lo : `ASRX_RST_BYTE;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      addr_ok_q <= 1'b0;
      addr_q    <= `ASRX_RST_BYTE;
      hrdata    <= 32'h00000000;
    end else begin
      wr_pend <= acc & hwrite;
      if (acc) addr_q <= a;
      if (acc) addr_ok_q <= addr_ok;
      if (acc) hrdata <= rd_acc ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {global_irq_enable, peripheral_irq_enable} <= {2{`ASRX_RST_BIT}};
      {receive_irq_enable, receive_irq_priority} <= {2{`ASRX_RST_BIT}};
      {serial_port_enable, nine_bit_receive_enable} <= {2{`ASRX_RST_BIT}};
      {continuous_receive_enable, address_detect_enable} <= {2{`ASRX_RST_BIT}};
      {sync_mode, high_rate_select, wide_divisor_select} <= {3{`ASRX_RST_BIT}};
      {div_hi, div_lo} <= {2{`ASRX_RST_BYTE}};
    end else begin
      if (wr_int) global_irq_enable <= wd[`ASRX_GIE_BIT];
      if (wr_int) peripheral_irq_enable <= wd[`ASRX_PERIPHERAL_IRQ_ENABLE_BIT];
      if (wr_en) receive_irq_enable <= wd[`ASRX_RC_BIT];
      if (wr_pri) receive_irq_priority <= wd[`ASRX_RC_BIT];
      if (wr_rcs) begin
        serial_port_enable        <= wd[`ASRX_SERIAL_PORT_ENABLE_BIT];
        nine_bit_receive_enable   <= wd[`ASRX_RX9_BIT];
        continuous_receive_enable <= wd[`ASRX_CONTINUOUS_RECEIVE_ENABLE_BIT];
        address_detect_enable     <= wd[`ASRX_ADDRESS_DETECT_ENABLE_BIT];
      end
      if (wr_txs) sync_mode <= wd[`ASRX_SYNC_BIT];
      if (wr_txs) high_rate_select <= wd[`ASRX_HIGH_RATE_SELECT_BIT];
      if (wr_baud) wide_divisor_select <= wd[`ASRX_WIDE_DIVISOR_SELECT_BIT];
      if (wr_dhi) div_hi <= wd;
      if (wr_dlo) div_lo <= wd;
    end
  end

  // ----------------------------------------------------------------
  // Line synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {rx_s1, rx_s2, rx_s3} <= {3{`ASRX_RST_LINE}};
      rx_level <= `ASRX_RST_LINE;
      rx_prev  <= `ASRX_RST_LINE;
    end else begin
      {rx_s1, rx_s2, rx_s3} <= {receive_line, rx_s1, rx_s2};
      if (rx_s2 == rx_s3) rx_level <= rx_s3;
      rx_prev <= rx_level;
    end
  end

  // ----------------------------------------------------------------
  // Mode and event decode
  // ----------------------------------------------------------------
  wire        async_on  = serial_port_enable & ~sync_mode;
  wire        wue_ok    = wakeup_enable & async_on;
  wire        rx_go     = async_on & continuous_receive_enable & ~overrun_error_flag & ~sleep;
  wire        rx_fall   = rx_prev & ~rx_level;
  wire        rx_rise   = ~rx_prev & rx_level;
  wire        fast      = wide_divisor_select & high_rate_select;
  wire        x64       = ~wide_divisor_select & ~high_rate_select;
  wire [15:0] divisor   = wide_divisor_select ? {div_hi, div_lo} : {8'h00, div_lo};
  wire        brg_wrap  = brg_cnt == divisor;
  wire        brg_run   = async_on & ~sleep;
  wire        tick      = brg_run & brg_wrap & (~x64 | (pre_cnt == `ASRX_PRE_X64));
  wire [3:0]  last_tk   = fast ? `ASRX_LAST_FAST : `ASRX_LAST_STD;
  wire [3:0]  vote_lo   = fast ? `ASRX_VOTE_FAST : `ASRX_VOTE_STD;
  wire [3:0]  stop_pt   = fast ? `ASRX_STOP_FAST : `ASRX_STOP_STD;
  wire [3:0]  vote_hi   = 4'(vote_lo + 4'h2);
  wire        at_vote   = tick & (tick_cnt >= vote_lo) & (tick_cnt <= vote_hi);
  wire        maj       = (vote[0] & vote[1]) | (vote[0] & vote[2]) | (vote[1] & vote[2]);
  wire        bit_end   = tick & (tick_cnt == last_tk);
  wire        stop_end  = tick & (tick_cnt == stop_pt);
  wire [3:0]  last_bit  = nine_bit_receive_enable ? `ASRX_BITS_NINE : `ASRX_BITS_EIGHT;
  wire        in_wake   = (state == ASRX_WAKE_FALL) | (state == ASRX_WAKE_RISE);
  wire        in_rx     = (state == ASRX_START) | (state == ASRX_DATA) | (state == ASRX_STOP);
  wire        start_go  = rx_idle & ~wue_ok & rx_go & rx_fall;
  wire        frame_done = (state == ASRX_STOP) & stop_end;
  wire        addr_mode = nine_bit_receive_enable & address_detect_enable;
  wire        accept    = ~addr_mode | shreg[8];
  wire        buf_full  = receive_complete_flag & ~rd_rxbuf;
  wire        load_evt  = frame_done & accept & ~buf_full;
  wire        ovr_evt   = frame_done & accept & buf_full;
  wire        wake_evt  = wue_ok & (state == ASRX_WAKE_FALL) & rx_fall;
  wire        wue_clr   = (state == ASRX_WAKE_RISE) & rx_rise;

  // ----------------------------------------------------------------
  // Baud generator and bit timing
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      brg_cnt  <= 16'h0000;
      pre_cnt  <= 2'h0;
      tick_cnt <= 4'h0;
      vote     <= 3'h7;
    end else begin
      if (start_go || !brg_run) begin
        brg_cnt <= 16'h0000;
        pre_cnt <= 2'h0;
      end else if (brg_wrap) begin
        brg_cnt <= 16'h0000;
        pre_cnt <= 2'(pre_cnt + 2'h1);
      end else begin
        brg_cnt <= 16'(brg_cnt + 16'h0001);
      end
      if (start_go) tick_cnt <= 4'h0;
      else if (tick) tick_cnt <= (tick_cnt == last_tk) ? 4'h0 : 4'(tick_cnt + 4'h1);
      if (at_vote) vote <= {vote[1:0], rx_level};
    end
  end

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      ASRX_IDLE:      if (start_go) next_state = ASRX_START;
      ASRX_START:     if (bit_end) next_state = maj ? ASRX_IDLE : ASRX_DATA;
      ASRX_DATA:      if (bit_end && bit_idx == last_bit) next_state = ASRX_STOP;
      ASRX_STOP:      if (stop_end) next_state = ASRX_IDLE;
      ASRX_WAKE_FALL: if (wake_evt) next_state = ASRX_WAKE_RISE;
      ASRX_WAKE_RISE: if (wue_clr) next_state = ASRX_IDLE;
    endcase
    if (wue_ok && !in_wake) next_state = ASRX_WAKE_FALL;
    else if (!wue_ok && in_wake) next_state = ASRX_IDLE;
    else if (!rx_go && in_rx) next_state = ASRX_IDLE;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state   <= ASRX_IDLE;
      bit_idx <= 4'h0;
      shreg   <= 9'h000;
    end else begin
      state <= next_state;
      if (state == ASRX_START) bit_idx <= 4'h0;
      else if (state == ASRX_DATA && bit_end) begin
        shreg[bit_idx] <= maj;
        bit_idx        <= 4'(bit_idx + 4'h1);
      end
      if (start_go) shreg <= 9'h000;
    end
  end

  // ----------------------------------------------------------------
  // Receive buffer, flags and wake-up enable
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_data               <= `ASRX_RST_BYTE;
      ninth_received_bit    <= `ASRX_RST_BIT;
      framing_error_flag    <= `ASRX_RST_BIT;
      overrun_error_flag    <= `ASRX_RST_BIT;
      receive_complete_flag <= `ASRX_RST_BIT;
      wakeup_enable         <= `ASRX_RST_BIT;
    end else begin
      if (load_evt) begin
        rx_data            <= shreg[7:0];
        ninth_received_bit <= shreg[8];
        framing_error_flag <= ~maj;
      end
      if (!continuous_receive_enable) {overrun_error_flag, framing_error_flag} <= 2'b00;
      else if (ovr_evt) overrun_error_flag <= 1'b1;
      receive_complete_flag <= load_evt | wake_evt | (receive_complete_flag & ~rd_rxbuf);
      if (wr_baud) wakeup_enable <= wd[`ASRX_WUE_BIT];
      else if (wue_clr) wakeup_enable <= 1'b0;
    end
  end

  wire irq_on = receive_complete_flag & receive_irq_enable;
  assign irq_high     = irq_on & global_irq_enable & receive_irq_priority;
  assign irq_low      = irq_on & global_irq_enable & peripheral_irq_enable & ~receive_irq_priority;
  assign wake_request = sleep & wue_ok & (state == ASRX_WAKE_FALL) & ~receive_line;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_read_clears;
    rd_rxbuf && !load_evt && !wake_evt |=> !receive_complete_flag;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("flag not cleared by buffer read");
  property p_wake_flag;
    wake_evt |=> receive_complete_flag && state == ASRX_WAKE_RISE;
  endproperty
  a_wake_flag: assert property (p_wake_flag) else $error("wake event did not set flag");
  property p_wue_clear;
    wue_clr && !wr_baud |=> !wakeup_enable ##1 rx_idle;
  endproperty
  a_wue_clear: assert property (p_wue_clear) else $error("wake enable not cleared");
  property p_wake_hold;
    wue_ok && !wue_clr && !wr_baud |=> in_wake;
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("reception not idled in wake mode");
  property p_need_continuous_receive_enable;
    rx_idle && !continuous_receive_enable |=> !in_rx;
  endproperty
  a_need_continuous_receive_enable: assert property (p_need_continuous_receive_enable) else $error("frame started without receive enable");
  property p_err_clear;
    !continuous_receive_enable |=> !overrun_error_flag && !framing_error_flag;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("errors kept with receive disabled");
  property p_overrun_halts;
    overrun_error_flag |-> !start_go;
  endproperty
  a_overrun_halts: assert property (p_overrun_halts) else $error("reception while overrun");
  property p_addr_discard;
    frame_done && addr_mode && !shreg[8] && !rd_rxbuf |=> $stable(rx_data) && $stable(receive_complete_flag);
  endproperty
  a_addr_discard: assert property (p_addr_discard) else $error("address frame not discarded");
  property p_frame_load;
    load_evt |=> receive_complete_flag && rx_data == $past(shreg[7:0]);
  endproperty
  a_frame_load: assert property (p_frame_load) else $error("completed frame not loaded");
  property p_bit_count;
    state == ASRX_DATA && next_state == ASRX_STOP |-> bit_idx == last_bit;
  endproperty
  a_bit_count: assert property (p_bit_count) else $error("wrong data bit count");
  property p_irq_route;
    irq_on && global_irq_enable && peripheral_irq_enable |-> irq_high != irq_low;
  endproperty
  a_irq_route: assert property (p_irq_route) else $error("interrupt not routed to one level");

  c_frame: cover property (load_evt);
  c_wake: cover property (wake_evt ##[1:1000] wue_clr);
  c_overrun: cover property (ovr_evt);
  c_framing: cover property (load_evt && !maj);

endmodule // asrx_receiver
`default_nettype wire

/* File: bench/asrx_line_tx.sv */
`default_nettype none
module asrx_line_tx #(
  parameter int BIT_CYCLES = 16
) (
  // Clock
  input  wire logic hclk,
  // Serial line, idle high
  output var logic  receive_line
);
  timeunit 1ns;
  timeprecision 1ps;

  initial receive_line = 1'b1;

  // Drives one level for n clock cycles, changing just after an edge
  task automatic hold(input logic v, input int n);
    @(posedge hclk);
    receive_line <= v;
    repeat (n - 1) @(posedge hclk);
  endtask

  // Start, data, stop, then two idle bits; a low stop is a deliberate fault
  task automatic send(input logic [8:0] d, input logic nine, input logic stop_v);
    hold(1'b0, BIT_CYCLES);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      hold(d[i], BIT_CYCLES);
    end
    hold(stop_v, BIT_CYCLES);
    hold(1'b1, 2 * BIT_CYCLES);
  endtask

  // All-zero wake character, long enough for start-up, then quiet time
  task automatic wake(input int n);
    hold(1'b0, n);
    hold(1'b1, 2 * BIT_CYCLES);
  endtask
endmodule // asrx_line_tx
`default_nettype wire

/* File: bench/tb_top.sv */
`default_nettype none
module tb_top import asrx_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic              hclk = 1'b0;
  logic              hresetn = 1'b0;
  logic              hsel = 1'b0;
  logic              hwrite = 1'b0;
  logic              sleep = 1'b0;
  logic [1:0]        htrans = 2'b00;
  logic [2:0]        hsize = 3'b010;
  logic [31:0]       haddr = 32'h0;
  logic [31:0]       hwdata = 32'h0;
  logic [31:0]       q;
  wire  logic        hready;
  wire  logic        hresp;
  wire  logic        irq_high;
  wire  logic        irq_low;
  wire  logic        wake_request;
  wire  logic        receive_line;
  wire  logic [31:0] hrdata;
  int                n_mismatch = 0;
  int                total_checks = 0;

  asrx_receiver i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .receive_line(receive_line), .sleep(sleep),
    .irq_high(irq_high), .irq_low(irq_low), .wake_request(wake_request)
  );
  // Divisor 0 with high rate: one tick per clock, sixteen clocks per bit
  asrx_line_tx #(.BIT_CYCLES(16)) i_tx (.hclk(hclk), .receive_line(receive_line));

  initial begin
    forever #2 hclk = ~hclk;
  end

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      n_mismatch++;
      complete_run();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    wait_rdy();
    q = hrdata;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, q, {24'h0, exp});
    chk("response", {31'h0, hresp}, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i <= 10; i++) begin
      rd(8'(i * 4), (i == 7) ? 8'h40 : 8'h00, "reset or unmapped");
    end
    bus(1'b1, 8'h04, 8'hff);
    rd(8'h04, 8'h00, "flags read only");
    bus(1'b1, 8'h20, 8'h5a);
    rd(8'h20, 8'h5a, "divisor high");
    bus(1'b1, 8'h18, 8'h04);
    bus(1'b1, 8'h00, 8'hc0);
    bus(1'b1, 8'h08, 8'h20);
    bus(1'b1, 8'h10, 8'h90);
    $display("Test registers done");
    for (int p = 0; p < 2; p++) begin
      bus(1'b1, 8'h0c, p ? 8'h20 : 8'h00);
      i_tx.send(9'h0a5 ^ 9'(p), 1'b0, 1'b1);
      rd(8'h04, 8'h20, "flag");
      chk("irq", {30'h0, irq_high, irq_low}, p ? 32'h2 : 32'h1);
      rd(8'h10, 8'h90, "status");
      rd(8'h14, 8'ha5 ^ 8'(p), "buffer");
      rd(8'h04, 8'h00, "flag after read");
      chk("irq off", {30'h0, irq_high, irq_low}, 32'h0);
    end
    $display("Test eight-bit frames done");
    bus(1'b1, 8'h10, 8'hd0);
    i_tx.send(9'h1c3, 1'b1, 1'b1);
    rd(8'h10, 8'hd1, "ninth bit");
    rd(8'h14, 8'hc3, "nine-bit data");
    bus(1'b1, 8'h10, 8'hd8);
    i_tx.send(9'h055, 1'b1, 1'b1);
    rd(8'h04, 8'h00, "data frame dropped");
    i_tx.send(9'h1aa, 1'b1, 1'b1);
    rd(8'h14, 8'haa, "address frame");
    bus(1'b1, 8'h10, 8'hd0);
    i_tx.send(9'h011, 1'b1, 1'b1);
    rd(8'h14, 8'h11, "data after address");
    $display("Test nine-bit and address done");
    bus(1'b1, 8'h10, 8'h90);
    i_tx.send(9'h0f0, 1'b0, 1'b0);
    rd(8'h10, 8'h94, "framing");
    rd(8'h14, 8'hf0, "framed byte");
    i_tx.send(9'h012, 1'b0, 1'b1);
    i_tx.send(9'h034, 1'b0, 1'b1);
    rd(8'h10, 8'h92, "overrun");
    rd(8'h14, 8'h12, "kept byte");
    i_tx.send(9'h056, 1'b0, 1'b1);
    rd(8'h04, 8'h00, "halted");
    bus(1'b1, 8'h10, 8'h80);
    rd(8'h10, 8'h80, "errors cleared");
    i_tx.send(9'h078, 1'b0, 1'b1);
    rd(8'h04, 8'h00, "receive off");
    bus(1'b1, 8'h10, 8'h90);
    sleep <= 1'b1;
    i_tx.send(9'h09a, 1'b0, 1'b1);
    sleep <= 1'b0;
    rd(8'h04, 8'h00, "sleep blocks");
    bus(1'b1, 8'h18, 8'h14);
    bus(1'b1, 8'h1c, 8'h02);
    rd(8'h1c, 8'h42, "no wake in sync mode");
    bus(1'b1, 8'h18, 8'h04);
    $display("Test errors and sleep done");
    bus(1'b1, 8'h1c, 8'h02);
    sleep <= 1'b1;
    fork
      i_tx.wake(160);
      begin
        @(posedge hclk);
        #1;
        chk("wake request", {31'h0, wake_request}, 32'h1);
        repeat (20) @(posedge hclk);
        sleep <= 1'b0;
        rd(8'h04, 8'h20, "wake flag");
        bus(1'b0, 8'h1c, 8'h00);
        chk("wake held", q, 32'h2);
      end
    join
    bus(1'b0, 8'h1c, 8'h00);
    chk("wake cleared", q, 32'h40);
    chk("wake request off", {31'h0, wake_request}, 32'h0);
    bus(1'b0, 8'h14, 8'h00);
    rd(8'h04, 8'h00, "wake flag cleared");
    i_tx.send(9'h05c, 1'b0, 1'b1);
    rd(8'h14, 8'h5c, "normal after wake");
    $display("Test wake-up done");
    // Wide divisor 3 with high rate: four ticks per bit, sixteen clocks per bit
    bus(1'b1, 8'h20, 8'h00);
    bus(1'b1, 8'h24, 8'h03);
    bus(1'b1, 8'h1c, 8'h08);
    rd(8'h1c, 8'h48, "wide divisor select");
    i_tx.send(9'h03c, 1'b0, 1'b1);
    rd(8'h04, 8'h20, "fast flag");
    rd(8'h14, 8'h3c, "fast data");
    $display("Test fast sampling done");
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
